/* rtl/cms_pkg.sv */
package cms_pkg;

  // ****************************************************************
  // Register map and fields
  // ****************************************************************
  localparam logic [5:0] ADDR_STATUS     = 6'h00;
  localparam logic [5:0] ADDR_CONTROL    = 6'h04;
  localparam logic [5:0] ADDR_OUTPUTS    = 6'h08;
  localparam logic [5:0] ADDR_INPUTS     = 6'h0C;
  localparam logic [5:0] ADDR_IRQ_STATUS = 6'h10;
  localparam logic [5:0] ADDR_IRQ_MASK   = 6'h14;
  localparam logic [5:0] ADDR_CARD_ADDR  = 6'h18;
  localparam logic [5:0] ADDR_CARD_DATA  = 6'h1C;
  localparam logic [5:0] ADDR_REMOTE_OUT = 6'h20;

  localparam int IRQ_FAULT   = 0;
  localparam int IRQ_REFUSED = 1;
  localparam int IRQ_RIO_OUT = 2;
  localparam int IRQ_CARD    = 3;
  localparam int IRQ_BITS    = 4;

  localparam logic [31:0] CONTROL_RST = 32'h0000_0000;
  localparam logic [31:0] OUTPUTS_RST = 32'h0000_0000;
  localparam logic [31:0] MASK_RST    = 32'h0000_0000;

  // ****************************************************************
  // Sizes and timing
  // ****************************************************************
  localparam int IN_POINTS   = 12;
  localparam int OUT_POINTS  = 8;
  localparam int CARD_BYTES  = 16384;
  localparam int CARD_AW     = 14;
  localparam int CARD_PROGS  = 18;
  localparam int WORD_W      = 5;
  localparam int CLK_MHZ     = 250;
  localparam int BLINK_MS    = 250;
  localparam int ACT_HOLD_MS = 100;
  localparam int CARD_ACC_NS = 40;
  localparam int BLINK_CYC   = BLINK_MS * CLK_MHZ * 1000;
  localparam int ACT_CYC     = ACT_HOLD_MS * CLK_MHZ * 1000;
  localparam int CARD_CYC    = (CARD_ACC_NS * CLK_MHZ + 999) / 1000;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [2:0] {
    MODE_INIT = 3'b001,
    MODE_RUN  = 3'b010,
    MODE_PROG = 3'b100
  } cms_mode_t;

  typedef struct packed {
    logic              valid;
    logic              we;
    logic [WORD_W-1:0] addr;
    logic [15:0]       wdata;
  } cms_rio_req_t;

  typedef struct packed {
    logic              console_at_start;
    logic [WORD_W-1:0] out_word;
    logic [WORD_W-1:0] base_word;
    logic              card_busy;
    logic              bus_active;
    logic              fault;
    logic              prog_mode;
    logic              run_mode;
  } cms_status_t;

endpackage : cms_pkg

/* rtl/cms_top.sv */
// Overview of operation
// (RQ1) No console at power-up: enter run mode, ignoring the selector switch.
// (RQ2) Console at power-up: selector run gives run mode, program gives program mode.
// (RQ3) Run mode executes the program; program mode halts execution for editing.
// (RQ4) Power indicator lit whenever power is applied.
// (RQ5) Run indicator lit only in run mode without a fault.
// (RQ6) Bus indicator flashes during remote bus traffic, steady on error.
// (RQ7) Error indicator lit whenever self-diagnosis reports an error.
// (RQ8) Base word is the five address switches in binary, first switch LSB.
// (RQ9) Two consecutive remote words: one input word, one output word.
// (RQ10) Base word 30 occupies words 30 and 31.
// (RQ11) Master should use all-even or all-odd base words to avoid overlap.
// (RQ12) Twelve discrete inputs and eight discrete outputs.
// (RQ13) Card writes refused while the write-protect switch is on.
// (RQ14) Card access indicator lit for the whole of every card access.
// (RQ15) Card holds 16 kilobytes of storage, room for eighteen programs.
module cms_top #(
  parameter int BLINK_CYCLES = cms_pkg::BLINK_CYC,
  parameter int ACT_CYCLES   = cms_pkg::ACT_CYC
) (
  // Clock and reset
  input  wire logic                             sys_clk_i,
  input  wire logic                             rst_n_i,
  // Avalon-MM slave
  input  wire logic [5:0]                       avs_address_i,
  input  wire logic                             avs_read_i,
  input  wire logic                             avs_write_i,
  input  wire logic [3:0]                       avs_byteenable_i,
  input  wire logic [31:0]                      avs_writedata_i,
  output logic [31:0]                           avs_readdata_o,
  output logic                                  avs_waitrequest_o,
  // Interrupt
  output logic                                  irq_o,
  // Switches and diagnosis
  input  wire logic                             console_present_i,
  input  wire logic                             edit_mode_setting_i,
  input  wire logic                             addr_switch_bit0_i,
  input  wire logic                             addr_switch_bit1_i,
  input  wire logic                             addr_switch_bit2_i,
  input  wire logic                             addr_switch_bit3_i,
  input  wire logic                             addr_switch_bit4_i,
  input  wire logic                             diag_error_i,
  input  wire logic                             card_protect_i,
  // Discrete points
  input  wire logic [cms_pkg::IN_POINTS-1:0]    in_points_i,
  output logic [cms_pkg::OUT_POINTS-1:0]        out_points_o,
  output logic                                  exec_enable_o,
  // Remote I/O bus
  input  wire cms_pkg::cms_rio_req_t            rio_req_i,
  output logic [15:0]                           rio_rdata_o,
  output logic                                  rio_ack_o,
  // Indicators
  output logic                                  power_indicator_o,
  output logic                                  run_indicator_o,
  output logic                                  bus_indicator_o,
  output logic                                  error_indicator_o,
  output logic                                  card_access_indicator_o
);

  // ****************************************************************
  // Start-up mode
  // ****************************************************************
  cms_pkg::cms_mode_t mode_reg;
  cms_pkg::cms_mode_t mode_next;
  logic               console_start_reg;

  // The straps are sampled by a clocked step after reset release, never by the reset itself.
  always_comb begin
    case (mode_reg)
      cms_pkg::MODE_INIT: begin
        if (!console_present_i) begin
          mode_next = cms_pkg::MODE_RUN;                              // [RQ1]
        end else if (edit_mode_setting_i) begin
          mode_next = cms_pkg::MODE_PROG;                             // [RQ2]
        end else begin
          mode_next = cms_pkg::MODE_RUN;                              // [RQ2]
        end
      end
      cms_pkg::MODE_RUN:  mode_next = cms_pkg::MODE_RUN;
      cms_pkg::MODE_PROG: mode_next = cms_pkg::MODE_PROG;
      default:            mode_next = cms_pkg::MODE_INIT;
    endcase
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mode_reg          <= cms_pkg::MODE_INIT;
      console_start_reg <= 1'b0;
    end else begin
      mode_reg <= mode_next;
      if (mode_reg == cms_pkg::MODE_INIT) begin
        console_start_reg <= console_present_i;
      end
    end
  end

  // ****************************************************************
  // Bus decode
  // ****************************************************************
  logic        ack_reg;
  logic [31:0] control_reg;
  logic [31:0] outputs_reg;
  logic [31:0] mask_reg;
  logic [cms_pkg::IRQ_BITS-1:0] irq_status_reg;
  logic [cms_pkg::CARD_AW-1:0]  card_addr_reg;
  logic [15:0] remote_out_reg;

  wire        bus_req   = avs_read_i | avs_write_i;
  wire        wr_done   = avs_write_i & ack_reg;
  wire [31:0] be_mask   = {{8{avs_byteenable_i[3]}}, {8{avs_byteenable_i[2]}},
                           {8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};
  wire [31:0] wmasked   = avs_writedata_i & be_mask;
  wire        wr_ctrl   = wr_done & (avs_address_i == cms_pkg::ADDR_CONTROL);
  wire        wr_outs   = wr_done & (avs_address_i == cms_pkg::ADDR_OUTPUTS);
  wire        wr_istat  = wr_done & (avs_address_i == cms_pkg::ADDR_IRQ_STATUS);
  wire        wr_mask   = wr_done & (avs_address_i == cms_pkg::ADDR_IRQ_MASK);
  wire        wr_caddr  = wr_done & (avs_address_i == cms_pkg::ADDR_CARD_ADDR);
  wire        wr_cdata  = wr_done & (avs_address_i == cms_pkg::ADDR_CARD_DATA);
  wire        rd_cdata  = avs_read_i & ack_reg & (avs_address_i == cms_pkg::ADDR_CARD_DATA);

  // One wait cycle on every access: the answer comes on the second edge.
  assign avs_waitrequest_o = bus_req & ~ack_reg;

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= bus_req & ~ack_reg;
    end
  end

  // ****************************************************************
  // Mode, fault and execution
  // ****************************************************************
  wire run_mode  = (mode_reg == cms_pkg::MODE_RUN);
  wire prog_mode = (mode_reg == cms_pkg::MODE_PROG);
  wire fault     = diag_error_i | control_reg[0];
  wire run_ok    = run_mode & ~fault;
  logic fault_d_reg;

  assign exec_enable_o     = run_mode;                                  // [RQ3]
  assign power_indicator_o = 1'b1;                                      // [RQ4]

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      run_indicator_o   <= 1'b0;
      error_indicator_o <= 1'b0;
      out_points_o      <= '0;
      fault_d_reg       <= 1'b0;
    end else begin
      run_indicator_o   <= run_ok;                                      // [RQ5]
      error_indicator_o <= fault;                                       // [RQ7]
      // Outputs go dead while halted so an edit cannot drive the plant.
      out_points_o      <= run_mode ? outputs_reg[cms_pkg::OUT_POINTS-1:0] : '0; // [RQ3] [RQ12]
      fault_d_reg       <= fault;
    end
  end

  // ****************************************************************
  // Remote I/O words
  // ****************************************************************
  wire [cms_pkg::WORD_W-1:0] base_word = {addr_switch_bit4_i, addr_switch_bit3_i,
                                          addr_switch_bit2_i, addr_switch_bit1_i,
                                          addr_switch_bit0_i}; // [RQ8]
  // Thirty-one wraps to zero here; the master is expected to keep allocations apart.
  wire [cms_pkg::WORD_W-1:0] out_word  = base_word + 5'h01;            // [RQ9] [RQ10] [RQ11]
  wire rio_in_hit  = rio_req_i.valid & ~rio_req_i.we & (rio_req_i.addr == base_word); // [RQ9]
  wire rio_out_hit = rio_req_i.valid & rio_req_i.we & (rio_req_i.addr == out_word);   // [RQ9]

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rio_rdata_o    <= 16'h0000;
      rio_ack_o      <= 1'b0;
      remote_out_reg <= 16'h0000;
    end else begin
      rio_ack_o <= rio_in_hit | rio_out_hit;
      if (rio_in_hit) begin
        rio_rdata_o <= {4'h0, in_points_i};                             // [RQ12]
      end
      if (rio_out_hit) begin
        remote_out_reg <= rio_req_i.wdata;
      end
    end
  end

  // ****************************************************************
  // Bus activity indicator
  // ****************************************************************
  logic [31:0] act_cnt_reg;
  logic [31:0] blink_cnt_reg;
  logic        blink_reg;
  wire         bus_active = (act_cnt_reg != 32'h0000_0000);
  wire         blink_tick = (blink_cnt_reg == 32'(BLINK_CYCLES - 1));

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      act_cnt_reg     <= 32'h0000_0000;
      blink_cnt_reg   <= 32'h0000_0000;
      blink_reg       <= 1'b0;
      bus_indicator_o <= 1'b0;
    end else begin
      if (rio_in_hit | rio_out_hit) begin
        act_cnt_reg <= 32'(ACT_CYCLES);
      end else if (bus_active) begin
        act_cnt_reg <= act_cnt_reg - 32'h0000_0001;
      end
      blink_cnt_reg <= blink_tick ? 32'h0000_0000 : blink_cnt_reg + 32'h0000_0001;
      if (blink_tick) begin
        blink_reg <= ~blink_reg;
      end
      bus_indicator_o <= fault | (bus_active & blink_reg);              // [RQ6]
    end
  end

  // ****************************************************************
  // Memory card
  // ****************************************************************
  logic [7:0]  card_mem [cms_pkg::CARD_BYTES];                          // [RQ15]
  logic [7:0]  card_rdata_reg;
  logic [7:0]  card_cnt_reg;
  wire         card_busy    = (card_cnt_reg != 8'h00);
  wire         card_wr_try  = wr_cdata & avs_byteenable_i[0];
  wire         card_refused = card_wr_try & card_protect_i;             // [RQ13]
  wire         card_start   = (card_wr_try & ~card_protect_i) | rd_cdata;
  wire         card_done    = (card_cnt_reg == 8'h01);

  always_ff @(posedge sys_clk_i) begin
    if (card_wr_try & ~card_protect_i) begin
      card_mem[card_addr_reg] <= avs_writedata_i[7:0];                  // [RQ13]
    end
    card_rdata_reg <= card_mem[card_addr_reg];
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      card_cnt_reg            <= 8'h00;
      card_access_indicator_o <= 1'b0;
    end else begin
      if (card_start) begin
        card_cnt_reg <= 8'(cms_pkg::CARD_CYC);
      end else if (card_busy) begin
        card_cnt_reg <= card_cnt_reg - 8'h01;
      end
      card_access_indicator_o <= card_start | card_busy;                // [RQ14]
    end
  end

  // ****************************************************************
  // Software registers and interrupts
  // ****************************************************************
  wire [cms_pkg::IRQ_BITS-1:0] irq_events = {card_done, rio_out_hit, card_refused,
                                             fault & ~fault_d_reg};
  // Set wins over a clear that lands in the same cycle.
  wire [cms_pkg::IRQ_BITS-1:0] irq_status_next =
    (irq_status_reg & ~(wr_istat ? wmasked[cms_pkg::IRQ_BITS-1:0] : '0)) | irq_events;

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      control_reg    <= cms_pkg::CONTROL_RST;
      outputs_reg    <= cms_pkg::OUTPUTS_RST;
      mask_reg       <= cms_pkg::MASK_RST;
      irq_status_reg <= '0;
      card_addr_reg  <= '0;
      irq_o          <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        control_reg <= (control_reg & ~be_mask) | (wmasked & 32'h0000_0001);
      end
      if (wr_outs) begin
        outputs_reg <= (outputs_reg & ~be_mask) | (wmasked & 32'h0000_00FF);
      end
      if (wr_mask) begin
        mask_reg <= (mask_reg & ~be_mask) | (wmasked & 32'h0000_000F);
      end
      if (wr_caddr) begin
        card_addr_reg <= (card_addr_reg & ~be_mask[13:0]) | wmasked[13:0];
      end
      irq_status_reg <= irq_status_next;
      irq_o          <= |(irq_status_next & mask_reg[cms_pkg::IRQ_BITS-1:0]);
    end
  end

  cms_pkg::cms_status_t status;
  assign status.console_at_start = console_start_reg;
  assign status.out_word         = out_word;
  assign status.base_word        = base_word;
  assign status.card_busy        = card_busy;
  assign status.bus_active       = bus_active;
  assign status.fault            = fault;
  assign status.prog_mode        = prog_mode;
  assign status.run_mode         = run_mode;

  logic [31:0] rd_mux;
  always_comb begin
    case (avs_address_i)
      cms_pkg::ADDR_STATUS:     rd_mux = {16'h0000, status};
      cms_pkg::ADDR_CONTROL:    rd_mux = control_reg;
      cms_pkg::ADDR_OUTPUTS:    rd_mux = outputs_reg;
      cms_pkg::ADDR_INPUTS:     rd_mux = {20'h0_0000, in_points_i};
      cms_pkg::ADDR_IRQ_STATUS: rd_mux = {28'h000_0000, irq_status_reg};
      cms_pkg::ADDR_IRQ_MASK:   rd_mux = mask_reg;
      cms_pkg::ADDR_CARD_ADDR:  rd_mux = {18'h0_0000, card_addr_reg};
      cms_pkg::ADDR_CARD_DATA:  rd_mux = {24'h00_0000, card_rdata_reg};
      cms_pkg::ADDR_REMOTE_OUT: rd_mux = {16'h0000, remote_out_reg};
      default:                  rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      avs_readdata_o <= 32'h0000_0000;
    end else if (avs_read_i & ~ack_reg) begin
      avs_readdata_o <= rd_mux;
    end
  end

endmodule : cms_top

/* bench/cms_top_asserts.sv */
module cms_top_asserts (
  // Clock and reset
  input wire logic                           sys_clk_i,
  input wire logic                           rst_n_i,
  // Bus, straps and switches
  input wire logic [5:0]                     avs_address_i,
  input wire logic                           avs_write_i,
  input wire logic                           avs_waitrequest_o,
  input wire logic                           console_present_i,
  input wire logic                           edit_mode_setting_i,
  input wire logic                           addr_switch_bit0_i,
  input wire logic                           addr_switch_bit1_i,
  input wire logic                           addr_switch_bit2_i,
  input wire logic                           addr_switch_bit3_i,
  input wire logic                           addr_switch_bit4_i,
  input wire logic                           diag_error_i,
  input wire logic                           card_protect_i,
  // Points and remote bus
  input wire logic [cms_pkg::IN_POINTS-1:0]  in_points_i,
  input wire logic [cms_pkg::OUT_POINTS-1:0] out_points_o,
  input wire logic                           exec_enable_o,
  input wire cms_pkg::cms_rio_req_t          rio_req_i,
  input wire logic [15:0]                    rio_rdata_o,
  input wire logic                           rio_ack_o,
  // Indicators
  input wire logic                           power_indicator_o,
  input wire logic                           run_indicator_o,
  input wire logic                           bus_indicator_o,
  input wire logic                           error_indicator_o,
  input wire logic                           card_access_indicator_o
);
  wire [4:0] base_w = {addr_switch_bit4_i, addr_switch_bit3_i, addr_switch_bit2_i,
                       addr_switch_bit1_i, addr_switch_bit0_i};
  wire [4:0] out_w = base_w + 5'h01;
  wire rd_hit = rio_req_i.valid && !rio_req_i.we && rio_req_i.addr == base_w;
  wire wr_hit = rio_req_i.valid && rio_req_i.we && rio_req_i.addr == out_w;
  wire card_wr = avs_write_i && !avs_waitrequest_o && avs_address_i == cms_pkg::ADDR_CARD_DATA;
  logic [1:0] cyc_reg;
  logic       run_exp_reg;

  // The straps are captured at the same edge the design decides its mode on.
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cyc_reg <= 2'h0;
      run_exp_reg <= 1'b0;
    end else begin
      if (cyc_reg == 2'h0) run_exp_reg <= !(console_present_i && edit_mode_setting_i);
      if (cyc_reg != 2'h3) cyc_reg <= cyc_reg + 2'h1;
    end
  end

  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);

  AST_POWER: assert property (power_indicator_o)
    else $error("power indicator dark");
  AST_MODE: assert property (cyc_reg == 2'h3 |-> exec_enable_o == run_exp_reg)
    else $error("mode does not follow straps");
  AST_RUN_MODE: assert property (run_indicator_o |-> exec_enable_o)
    else $error("run indicator outside run mode");
  AST_FAULT: assert property (diag_error_i [*3] |-> !run_indicator_o && bus_indicator_o && error_indicator_o)
    else $error("indicators wrong under fault");
  AST_OUT_ZERO: assert property (!exec_enable_o |-> out_points_o == '0)
    else $error("outputs driven while halted");
  AST_RIO_RD: assert property (rd_hit |=> rio_ack_o && rio_rdata_o == {4'h0, $past(in_points_i)})
    else $error("input word read wrong");
  AST_RIO_WR: assert property (wr_hit |=> rio_ack_o)
    else $error("output word write not taken");
  AST_RIO_MISS: assert property (!rd_hit && !wr_hit |=> !rio_ack_o)
    else $error("ack without a hit");
  AST_CARD_ACC: assert property (card_wr && !card_protect_i |-> ##[1:2] card_access_indicator_o [*8])
    else $error("card access indicator short");
  AST_CARD_PROT: assert property (card_wr && card_protect_i && !card_access_indicator_o |=> !card_access_indicator_o [*3])
    else $error("protected write accessed card");

  COV_RD: cover property (rd_hit);
  COV_WR: cover property (wr_hit);
  COV_PROT: cover property (card_wr && card_protect_i);
  COV_FAULT: cover property (diag_error_i [*3]);
endmodule : cms_top_asserts

bind cms_top cms_top_asserts cms_top_asserts_i (
  .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .avs_address_i(avs_address_i),
  .avs_write_i(avs_write_i), .avs_waitrequest_o(avs_waitrequest_o),
  .console_present_i(console_present_i), .edit_mode_setting_i(edit_mode_setting_i),
  .addr_switch_bit0_i(addr_switch_bit0_i), .addr_switch_bit1_i(addr_switch_bit1_i),
  .addr_switch_bit2_i(addr_switch_bit2_i), .addr_switch_bit3_i(addr_switch_bit3_i),
  .addr_switch_bit4_i(addr_switch_bit4_i), .diag_error_i(diag_error_i),
  .card_protect_i(card_protect_i), .in_points_i(in_points_i), .out_points_o(out_points_o),
  .exec_enable_o(exec_enable_o), .rio_req_i(rio_req_i), .rio_rdata_o(rio_rdata_o),
  .rio_ack_o(rio_ack_o), .power_indicator_o(power_indicator_o),
  .run_indicator_o(run_indicator_o), .bus_indicator_o(bus_indicator_o),
  .error_indicator_o(error_indicator_o), .card_access_indicator_o(card_access_indicator_o));

/* bench/cms_rio_master.sv */
module cms_rio_master (
  // Clock
  input  wire logic            sys_clk_i,
  // Slave answer
  input  wire logic            rio_ack_i,
  input  wire logic [15:0]     rio_rdata_i,
  // Request
  output cms_pkg::cms_rio_req_t rio_req_o
);
  timeunit 1ns;
  timeprecision 1ps;

  initial rio_req_o = '0;

  // One slave sits on this bus, so its two words never overlap another unit's.
  task automatic xfer(input logic we, input logic [4:0] a, input logic [15:0] d,
                      output logic ack, output logic [15:0] q);
    @(posedge sys_clk_i);
    rio_req_o <= '{valid: 1'b1, we: we, addr: a, wdata: d};
    @(posedge sys_clk_i);
    // Released fields are inverted so a stale word never passes for a live one.
    rio_req_o <= '{valid: 1'b0, we: !we, addr: ~a, wdata: ~d};
    @(posedge sys_clk_i);
    ack = rio_ack_i;
    q = rio_rdata_i;
  endtask : xfer
endmodule : cms_rio_master

/* bench/tb_cms_top.sv */
module tb_cms_top;
  timeunit 1ns;
  timeprecision 1ps;

  logic                  clk, rst_n, rd, wr, waitreq, irq, con, edit, diag, prot, exen, ack;
  logic                  p_ind, r_ind, b_ind, e_ind, c_ind, got;
  logic [5:0]            adr;
  logic [31:0]           wdat, rbus, rdat;
  logic [4:0]            sw;
  logic [11:0]           inp;
  logic [7:0]            outp;
  logic [15:0]           rq, q;
  cms_pkg::cms_rio_req_t req;
  int                    n_errors, n_compared;

  cms_top #(.BLINK_CYCLES(4), .ACT_CYCLES(20)) cms_top_i (
    .sys_clk_i(clk), .rst_n_i(rst_n), .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr),
    .avs_byteenable_i(4'hf), .avs_writedata_i(wdat), .avs_readdata_o(rbus),
    .avs_waitrequest_o(waitreq), .irq_o(irq), .console_present_i(con),
    .edit_mode_setting_i(edit), .addr_switch_bit0_i(sw[0]), .addr_switch_bit1_i(sw[1]),
    .addr_switch_bit2_i(sw[2]), .addr_switch_bit3_i(sw[3]), .addr_switch_bit4_i(sw[4]),
    .diag_error_i(diag), .card_protect_i(prot), .in_points_i(inp), .out_points_o(outp),
    .exec_enable_o(exen), .rio_req_i(req), .rio_rdata_o(rq), .rio_ack_o(ack),
    .power_indicator_o(p_ind), .run_indicator_o(r_ind), .bus_indicator_o(b_ind),
    .error_indicator_o(e_ind), .card_access_indicator_o(c_ind));
  cms_rio_master cms_rio_master_i (.sys_clk_i(clk), .rio_ack_i(ack), .rio_rdata_i(rq),
                                   .rio_req_o(req));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // ********
  // Shared tasks
  // ********
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task avs(input logic w, input logic [5:0] a, input logic [31:0] d);
    int i;
    @(posedge clk);
    adr <= a;
    wdat <= d;
    rd <= !w;
    wr <= w;
    for (i = 0; i < 50; i++) begin
      @(posedge clk);
      if (waitreq === 1'b0) break;
    end
    if (i == 50) n_errors++;
    rdat = rbus;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask : avs

  task start(input logic c, input logic e);
    @(posedge clk);
    rst_n <= 1'b0;
    con <= c;
    edit <= e;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
  endtask : start

  task count_card(output int n);
    n = 0;
    repeat (30) begin
      @(negedge clk);
      if (c_ind === 1'b1) n++;
    end
  endtask : count_card

  task test_done;
    $display("errors %0d compared %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : test_done

  // ********
  // Scenarios
  // ********
  task t_mode;
    logic run;
    for (int i = 0; i < 4; i++) begin
      start(i[1], i[0]);
      run = !(i[1] && i[0]);
      chk("exec", exen, run);
      avs(1'b0, cms_pkg::ADDR_STATUS, 32'h0);
      chk("status mode", rdat[1:0], {!run, run});
      chk("run ind", r_ind, run);
      chk("power ind", p_ind, 1'b1);
    end
    avs(1'b1, cms_pkg::ADDR_OUTPUTS, 32'h0000_00ff);
    repeat (2) @(posedge clk);
    chk("halted outputs", outp, 8'h00);
    start(1'b1, 1'b0);
    $display("test mode done");
  endtask : t_mode

  task t_fault;
    diag <= 1'b1;
    repeat (4) @(posedge clk);
    repeat (6) begin
      @(negedge clk);
      chk("run ind fault", r_ind, 1'b0);
      chk("err ind", e_ind, 1'b1);
      chk("bus ind steady", b_ind, 1'b1);
    end
    diag <= 1'b0;
    repeat (4) @(posedge clk);
    avs(1'b1, cms_pkg::ADDR_CONTROL, 32'h0000_0001);
    repeat (2) @(negedge clk);
    chk("soft fault", e_ind, 1'b1);
    avs(1'b1, cms_pkg::ADDR_CONTROL, 32'h0000_0000);
    $display("test fault done");
  endtask : t_fault

  task t_remote;
    static logic [4:0] bases [3] = '{5'd0, 5'd21, 5'd30};
    int hi, lo;
    foreach (bases[k]) begin
      sw <= bases[k];
      inp <= 12'habc ^ 12'(bases[k]);
      repeat (3) @(posedge clk);
      cms_rio_master_i.xfer(1'b0, bases[k], 16'h0, got, q);
      chk("in ack", got, 1'b1);
      chk("in word", q, {4'h0, inp});
      cms_rio_master_i.xfer(1'b1, bases[k] + 5'd1, 16'h1234 + 16'(k), got, q);
      chk("out ack", got, 1'b1);
      hi = 0;
      lo = 0;
      repeat (12) begin
        @(negedge clk);
        if (b_ind === 1'b1) hi++;
        if (b_ind === 1'b0) lo++;
      end
      chk("bus flash", (hi > 0) && (lo > 0), 1'b1);
      cms_rio_master_i.xfer(1'b0, bases[k] + 5'd1, 16'h0, got, q);
      chk("wrong dir", got, 1'b0);
      cms_rio_master_i.xfer(1'b1, bases[k] + 5'd2, 16'h0, got, q);
      chk("miss", got, 1'b0);
      avs(1'b0, cms_pkg::ADDR_REMOTE_OUT, 32'h0);
      chk("remote out", rdat[15:0], 16'h1234 + 16'(k));
      avs(1'b0, cms_pkg::ADDR_STATUS, 32'h0);
      chk("words", rdat[14:5], {bases[k] + 5'd1, bases[k]});
    end
    avs(1'b1, cms_pkg::ADDR_OUTPUTS, 32'h0000_01a5);
    repeat (2) @(negedge clk);
    chk("outputs", outp, 8'ha5);
    avs(1'b0, cms_pkg::ADDR_INPUTS, 32'h0);
    chk("inputs", rdat, {20'h0, inp});
    avs(1'b0, 6'h3c, 32'h0);
    chk("unmapped", rdat, 32'h0);
    $display("test remote done");
  endtask : t_remote

  task t_card;
    int n;
    avs(1'b1, cms_pkg::ADDR_IRQ_MASK, 32'h0000_0008);
    avs(1'b1, cms_pkg::ADDR_IRQ_STATUS, 32'h0000_000f);
    avs(1'b1, cms_pkg::ADDR_CARD_ADDR, 32'h0000_3fff);
    avs(1'b1, cms_pkg::ADDR_CARD_DATA, 32'h0000_00a5);
    count_card(n);
    chk("access cycles", n, cms_pkg::CARD_CYC + 1);
    chk("irq done", irq, 1'b1);
    avs(1'b0, cms_pkg::ADDR_CARD_DATA, 32'h0);
    chk("top byte", rdat[7:0], 8'ha5);
    prot <= 1'b1;
    repeat (12) @(posedge clk);
    avs(1'b1, cms_pkg::ADDR_IRQ_STATUS, 32'h0000_000f);
    @(negedge clk);
    chk("irq cleared", irq, 1'b0);
    avs(1'b1, cms_pkg::ADDR_CARD_DATA, 32'h0000_005a);
    count_card(n);
    chk("protected access", n, 0);
    avs(1'b0, cms_pkg::ADDR_IRQ_STATUS, 32'h0);
    chk("refused flag", rdat[1], 1'b1);
    chk("irq masked", irq, 1'b0);
    avs(1'b0, cms_pkg::ADDR_CARD_DATA, 32'h0);
    chk("kept byte", rdat[7:0], 8'ha5);
    $display("test card done");
  endtask : t_card

  initial begin
    rst_n = 1'b0;
    {rd, wr, con, edit, diag, prot} = '0;
    adr = '0;
    wdat = '0;
    sw = '0;
    inp = '0;
    t_mode();
    t_fault();
    t_remote();
    t_card();
    test_done();
  end

  initial begin
    #100000;
    n_errors++;
    test_done();
  end
endmodule : tb_cms_top
